//--- src/status_led_annunciator.sv
// Our own choices: the APB slave port and the register offsets.
`include "annun_map.svh"
// Contract
// - power led steady when mains good
// - alarm flashes while alarm or clear unacked
// - alarm steady once everything acknowledged
// - reset clears alarm only if idle, acked
// - prealarm flashes unacked, steady when acked
// - prealarm off after every source cleared
// - trouble flashes unacked, steady when acked
// - trouble off after every source cleared
// - supervisory flashes unacked, steady when acked
// - supervisory off after every source cleared
// - silence press with alarms acked lights silence
// - silence off on reset or re-press
// - each accepted press toggles silenceable outputs, unless a panel reset lands in the same cycle
// - acknowledged conditions revert within a day
// - ignore silence presses within ten seconds
module status_led_annunciator #(
   parameter int N_SRC = 8,
   parameter int BLINK_HALF = 12500000,
   parameter int SILENCE_CYCLES = `SILENCE_HOLD_S * `CLK_HZ,
   parameter int REVERT_CYCLES = 32'h7fffffff
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // field inputs (asynchronous)
   input wire logic MAINS_OK,
   input wire logic [N_SRC-1:0] ALM_SET,
   input wire logic [N_SRC-1:0] ALM_CLR,
   input wire logic [N_SRC-1:0] PRE_SET,
   input wire logic [N_SRC-1:0] PRE_CLR,
   input wire logic [N_SRC-1:0] TRB_SET,
   input wire logic [N_SRC-1:0] TRB_CLR,
   input wire logic [N_SRC-1:0] SUP_SET,
   input wire logic [N_SRC-1:0] SUP_CLR,
   // indicators and outputs
   output logic LED_POWER,
   output logic LED_ALARM,
   output logic LED_PREALARM,
   output logic LED_TROUBLE,
   output logic LED_SUPERVISORY,
   output logic LED_SILENCE,
   output logic SILENCEABLE_ON,
   output logic IRQ
);
   localparam int NV = 8 * N_SRC + 1;
   // field inputs: two flops, then edge detect on second stage
   logic [NV-1:0] s1_q;
   logic [NV-1:0] s2_q;
   logic [NV-1:0] s3_q;
   wire [NV-1:0] raw = {MAINS_OK, ALM_SET, ALM_CLR, PRE_SET, PRE_CLR,
      TRB_SET, TRB_CLR, SUP_SET, SUP_CLR};
   wire [NV-1:0] rise = s2_q & ~s3_q;
   wire mains_ok = s2_q[NV-1];
   wire [N_SRC-1:0] alm_set = rise[8*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] alm_clr = rise[7*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] pre_set = rise[6*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] pre_clr = rise[5*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] trb_set = rise[4*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] trb_clr = rise[3*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] sup_set = rise[2*N_SRC-1 -: N_SRC];
   wire [N_SRC-1:0] sup_clr = rise[N_SRC-1:0];
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else if (CE)
      begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // apb decode; zero wait states
   wire wr = PSEL & PENABLE & PWRITE;
   wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
   wire hit_ctrl = (PADDR == `OFS_CTRL);
   wire hit_stat = (PADDR == `OFS_STAT);
   wire hit_ist = (PADDR == `OFS_IRQ_STAT);
   wire hit_msk = (PADDR == `OFS_IRQ_MASK);
   wire mapped = hit_ctrl | hit_stat | hit_ist | hit_msk;
   wire ack_p = wr & hit_ctrl & PWDATA[`CTRL_ACK];
   wire sil_p = wr & hit_ctrl & PWDATA[`CTRL_SILENCE];
   wire rst_p = wr & hit_ctrl & PWDATA[`CTRL_RESET];

   // panel reset: only when every alarm acked and no source alarming
   logic alm_act;
   logic alm_unack;
   logic pre_act;
   logic pre_unack;
   logic trb_act;
   logic trb_unack;
   logic sup_act;
   logic sup_unack;
   logic [3:0] rev;
   wire panel_reset = rst_p & ~alm_unack & ~(|s2_q[8*N_SRC-1 -: N_SRC]);

   class_track #(.N(N_SRC), .REVERT_CYCLES(REVERT_CYCLES)) u_alm (
      .clk(CLK), .rst(RST), .ce(CE),
      .ev_set(alm_set), .ev_clr(alm_clr),
      .ack(ack_p), .clear_all(panel_reset),
      .any_active(alm_act), .any_unack(alm_unack), .reverted(rev[annun_pkg::CL_ALM])
   );
   // pre-alarm, trouble, supervisory clear only by per-source clears
   class_track #(.N(N_SRC), .REVERT_CYCLES(REVERT_CYCLES)) u_pre (
      .clk(CLK), .rst(RST), .ce(CE),
      .ev_set(pre_set), .ev_clr(pre_clr), .ack(ack_p), .clear_all(1'b0),
      .any_active(pre_act), .any_unack(pre_unack), .reverted(rev[annun_pkg::CL_PRE])
   );
   class_track #(.N(N_SRC), .REVERT_CYCLES(REVERT_CYCLES)) u_trb (
      .clk(CLK), .rst(RST), .ce(CE),
      .ev_set(trb_set), .ev_clr(trb_clr), .ack(ack_p), .clear_all(1'b0),
      .any_active(trb_act), .any_unack(trb_unack), .reverted(rev[annun_pkg::CL_TRB])
   );
   class_track #(.N(N_SRC), .REVERT_CYCLES(REVERT_CYCLES)) u_sup (
      .clk(CLK), .rst(RST), .ce(CE),
      .ev_set(sup_set), .ev_clr(sup_clr), .ack(ack_p), .clear_all(1'b0),
      .any_active(sup_act), .any_unack(sup_unack), .reverted(rev[annun_pkg::CL_SUP])
   );

   // an alarm whose clear is unacked keeps the alarm led lit (flashing)
   logic alm_lit_q;
   wire alm_lit_d = panel_reset ? 1'b0 : (alm_act | alm_unack | alm_lit_q);

   logic blink;
   blink_gen #(.HALF_CYCLES(BLINK_HALF)) u_blink (
      .clk(CLK), .rst(RST), .ce(CE), .blink(blink)
   );

   // silence key with 10 s lockout
   logic [31:0] lock_q;
   logic sil_q;
   logic outs_on_q;
   wire lock_busy = (lock_q != 32'h0);
   wire sil_take = sil_p & ~lock_busy & ~alm_unack & alm_act;
   // each accepted press toggles silence, but a panel reset in the same cycle clears it
   wire sil_d = panel_reset ? 1'b0 : (sil_take ? ~sil_q : sil_q);

   // interrupts: sticky, w1c, event wins over clear
   logic [`IRQ_W-1:0] ist_q;
   logic [`IRQ_W-1:0] msk_q;
   wire [`IRQ_W-1:0] ev_irq = {|rev, panel_reset, sil_take};
   wire [`IRQ_W-1:0] w1c = (wr & hit_ist) ? PWDATA[`IRQ_W-1:0] : '0;
   wire [31:0] stat_word = {21'h0, sil_q, sup_unack, sup_act, trb_unack, trb_act,
      pre_unack, pre_act, alm_unack, alm_act, alm_lit_q, mains_ok};
   wire [31:0] rd_mux = hit_stat ? stat_word
      : hit_ist ? {29'h0, ist_q}
      : hit_msk ? {29'h0, msk_q} : 32'h0;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         alm_lit_q <= 1'b0;
         lock_q <= '0;
         sil_q <= 1'b0;
         outs_on_q <= 1'b1;
         ist_q <= '0;
         msk_q <= '0;
         PRDATA <= '0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         LED_POWER <= 1'b0;
         LED_ALARM <= 1'b0;
         LED_PREALARM <= 1'b0;
         LED_TROUBLE <= 1'b0;
         LED_SUPERVISORY <= 1'b0;
         LED_SILENCE <= 1'b0;
         SILENCEABLE_ON <= 1'b1;
         IRQ <= 1'b0;
      end
      else if (CE)
      begin
         alm_lit_q <= alm_lit_d;
         // lockout restarts on any press, accepted or not
         lock_q <= sil_p ? 32'(SILENCE_CYCLES) : (lock_busy ? lock_q - 32'h1 : lock_q);
         sil_q <= sil_d;
         outs_on_q <= ~sil_d;
         ist_q <= ev_irq | (ist_q & ~w1c);
         if (wr & hit_msk)
            msk_q <= PWDATA[`IRQ_W-1:0];
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & ~mapped;
         if (rd_setup)
            PRDATA <= rd_mux;
         LED_POWER <= mains_ok;
         LED_ALARM <= alm_unack ? blink : alm_lit_q;
         LED_PREALARM <= pre_unack ? blink : pre_act;
         LED_TROUBLE <= trb_unack ? blink : trb_act;
         LED_SUPERVISORY <= sup_unack ? blink : sup_act;
         LED_SILENCE <= sil_q;
         SILENCEABLE_ON <= outs_on_q;
         IRQ <= |(ist_q & msk_q);
      end
   end

   // power led follows synchronised mains one edge later
   a_power_follow: assert property (@(posedge CLK) disable iff (RST)
      CE && $past(CE) |-> LED_POWER == $past(mains_ok))
      else $error("power led does not follow mains");
   // steady pre-alarm while active and all acked
   a_pre_steady: assert property (@(posedge CLK) disable iff (RST)
      CE && pre_act && !pre_unack ##1 CE |-> LED_PREALARM)
      else $error("pre-alarm not steady when acked");
   a_trb_steady: assert property (@(posedge CLK) disable iff (RST)
      CE && trb_act && !trb_unack ##1 CE |-> LED_TROUBLE)
      else $error("trouble not steady when acked");
   a_sup_dark: assert property (@(posedge CLK) disable iff (RST)
      CE && !sup_act && !sup_unack ##1 CE |-> !LED_SUPERVISORY)
      else $error("supervisory lit with no source");
   a_reset_gate: assert property (@(posedge CLK) disable iff (RST)
      CE && panel_reset |=> !alm_lit_q && !alm_act)
      else $error("panel reset left alarm state behind");
   sequence s_take;
      CE && sil_take;
   endsequence
   a_sil_toggle: assert property (@(posedge CLK) disable iff (RST)
      s_take and !panel_reset |=> sil_q != $past(sil_q))
      else $error("silence press did not toggle");
   a_sil_lock: assert property (@(posedge CLK) disable iff (RST)
      CE && sil_p |=> !sil_take)
      else $error("silence press accepted inside lockout");
   a_sil_reset: assert property (@(posedge CLK) disable iff (RST)
      CE && panel_reset |=> !sil_q)
      else $error("silence not cleared by reset");
   a_alm_steady: assert property (@(posedge CLK) disable iff (RST)
      CE && alm_lit_q && !alm_unack ##1 CE |-> LED_ALARM)
      else $error("alarm not steady when all acked");
   a_alm_hold: assert property (@(posedge CLK) disable iff (RST)
      CE && alm_act && !panel_reset |=> alm_lit_q)
      else $error("alarm lit state dropped while active");

   // dark when nothing is active or open
   a_power_dark: assert property (@(posedge CLK) disable iff (RST)
      CE && !mains_ok |=> !LED_POWER)
      else $error("power led lit without mains");
   a_alm_dark: assert property (@(posedge CLK) disable iff (RST)
      CE && !alm_unack && !alm_lit_q |=> !LED_ALARM)
      else $error("alarm led lit after reset");
   a_pre_dark: assert property (@(posedge CLK) disable iff (RST)
      CE && !pre_act && !pre_unack |=> !LED_PREALARM)
      else $error("pre-alarm lit with no source");
   a_trb_dark: assert property (@(posedge CLK) disable iff (RST)
      CE && !trb_act && !trb_unack |=> !LED_TROUBLE)
      else $error("trouble lit with no source");
   // open conditions flash on the shared phase
   a_alm_flash: assert property (@(posedge CLK) disable iff (RST)
      CE && alm_unack |=> LED_ALARM == $past(blink))
      else $error("alarm not flashing when unacked");
   a_pre_flash: assert property (@(posedge CLK) disable iff (RST)
      CE && pre_unack |=> LED_PREALARM == $past(blink))
      else $error("pre-alarm not flashing when unacked");
   a_trb_flash: assert property (@(posedge CLK) disable iff (RST)
      CE && trb_unack |=> LED_TROUBLE == $past(blink))
      else $error("trouble not flashing when unacked");
   a_sup_flash: assert property (@(posedge CLK) disable iff (RST)
      CE && sup_unack |=> LED_SUPERVISORY == $past(blink))
      else $error("supervisory not flashing when unacked");
   a_sup_steady: assert property (@(posedge CLK) disable iff (RST)
      CE && sup_act && !sup_unack |=> LED_SUPERVISORY)
      else $error("supervisory not steady when acked");
   // a revert pulse always leaves its class open
   a_revert_flag: assert property (@(posedge CLK) disable iff (RST)
      (|rev) |-> (alm_unack || !rev[annun_pkg::CL_ALM])
         && (pre_unack || !rev[annun_pkg::CL_PRE])
         && (trb_unack || !rev[annun_pkg::CL_TRB])
         && (sup_unack || !rev[annun_pkg::CL_SUP]))
      else $error("revert pulse without open condition");

   // silence indicator and outputs move together
   sequence s_run2;
      CE ##1 CE;
   endsequence
   a_sil_led: assert property (@(posedge CLK) disable iff (RST)
      CE |=> LED_SILENCE == $past(sil_q))
      else $error("silence led does not follow state");
   a_outs_track: assert property (@(posedge CLK) disable iff (RST)
      s_run2 |=> SILENCEABLE_ON != LED_SILENCE)
      else $error("outputs and silence led disagree");
   a_reset_outs: assert property (@(posedge CLK) disable iff (RST)
      CE && panel_reset ##1 CE |=> SILENCEABLE_ON)
      else $error("outputs not restored by reset");
   // refused presses leave the silence state alone
   sequence s_refused;
      CE && sil_p && !panel_reset && (alm_unack || !alm_act || lock_busy);
   endsequence
   a_sil_refuse: assert property (@(posedge CLK) disable iff (RST)
      s_refused |=> sil_q == $past(sil_q))
      else $error("refused silence press changed state");
   // counter only runs down between presses
   a_lock_count: assert property (@(posedge CLK) disable iff (RST)
      CE && lock_busy && !sil_p |=> lock_q == $past(lock_q) - 32'h1)
      else $error("silence lockout not counting down");
endmodule

//--- src/annun_map.svh
`ifndef ANNUN_MAP_SVH
`define ANNUN_MAP_SVH
// apb register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00c
// control bits (write one = pulse)
`define CTRL_ACK 0
`define CTRL_SILENCE 1
`define CTRL_RESET 2
// irq bits
`define IRQ_SILENCE 0
`define IRQ_RESET 1
`define IRQ_REVERT 2
`define IRQ_W 3
// timing
`define SILENCE_HOLD_S 10
`define REVERT_HOURS 24
`define CLK_HZ 25000000
`endif

//--- src/annun_pkg.sv
package annun_pkg;
   typedef enum logic [1:0] {LED_OFF, LED_FLASH, LED_STEADY} led_mode_t;
   typedef enum logic [1:0] {CL_PRE, CL_TRB, CL_SUP, CL_ALM} class_t;
endpackage

//--- src/blink_gen.sv
// common blink phase for all flashing indicators
module blink_gen #(
   parameter int HALF_CYCLES = 12500000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   output logic blink
);
   logic [31:0] cnt_q;
   wire wrap = (cnt_q == 32'(HALF_CYCLES - 1));
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         blink <= 1'b0;
      end
      else if (ce)
      begin
         cnt_q <= wrap ? '0 : cnt_q + 32'h1;
         if (wrap)
            blink <= ~blink;
      end
   end
endmodule

//--- src/class_track.sv
// one event class: per-source active and unacknowledged bits
module class_track #(
   parameter int N = 8,
   parameter int REVERT_CYCLES = 32'h7fffffff
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [N-1:0] ev_set,
   input wire logic [N-1:0] ev_clr,
   input wire logic ack,
   input wire logic clear_all,
   output logic any_active,
   output logic any_unack,
   output logic reverted
);
   logic [N-1:0] act_q;
   logic [N-1:0] unack_q;
   logic [N-1:0] act_d;
   logic [N-1:0] unack_d;
   logic [31:0] age_q;
   wire age_done = (age_q == 32'(REVERT_CYCLES - 1));
   wire acked_hold = (|act_q) & ~(|unack_q);
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_src
         // set wins over clear, events win over ack
         assign act_d[i] = ev_set[i] | (act_q[i] & ~ev_clr[i] & ~clear_all);
         assign unack_d[i] = ev_set[i] | (ev_clr[i] & act_q[i])
            | (age_done & act_q[i]) | (unack_q[i] & ~ack & ~clear_all);
      end
   endgenerate
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         act_q <= '0;
         unack_q <= '0;
         age_q <= '0;
         reverted <= 1'b0;
      end
      else if (ce)
      begin
         act_q <= act_d;
         unack_q <= unack_d;
         age_q <= (acked_hold & ~age_done) ? age_q + 32'h1 : '0;
         reverted <= acked_hold & age_done;
      end
   end
   assign any_active = |act_q;
   assign any_unack = |unack_q;
endmodule

//--- verification/field_model.sv
module field_model (
   // bench clock
   input wire logic clk,
   // reports toward the panel, indexed by class
   output logic mains_ok,
   output logic [7:0] lvl [4],
   output logic [7:0] off [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      mains_ok = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         lvl[c] = 8'h00;
         off[c] = 8'h00;
      end
   end
   task automatic mains(input logic v);
      @(posedge clk);
      mains_ok <= v;
   endtask
   // a source keeps reporting until it clears, so reset can be refused
   task automatic raise(input int c, input int s);
      @(posedge clk);
      lvl[c][s] <= 1'b1;
   endtask
   // clear pulse is wide enough for the input synchronizers
   task automatic drop(input int c, input int s);
      @(posedge clk);
      lvl[c][s] <= 1'b0;
      off[c][s] <= 1'b1;
      repeat (3) @(posedge clk);
      off[c][s] <= 1'b0;
   endtask
endmodule

//--- verification/status_led_annunciator_tb_top.sv
`include "annun_map.svh"
module status_led_annunciator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REV = 400;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] rd;
   logic er;
   wire [31:0] prdata;
   wire pready, pslverr, irq, sil_on, mains;
   wire [5:0] leds;
   logic [7:0] lvl [4];
   logic [7:0] off [4];
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   field_model field_model_i (.clk(clk), .mains_ok(mains), .lvl(lvl), .off(off));
   status_led_annunciator #(.BLINK_HALF(4), .SILENCE_CYCLES(20),
      .REVERT_CYCLES(REV)) status_led_annunciator_i (.CLK(clk), .RST(rst), .CE(ce),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MAINS_OK(mains),
      .ALM_SET(lvl[3]), .ALM_CLR(off[3]), .PRE_SET(lvl[0]), .PRE_CLR(off[0]),
      .TRB_SET(lvl[1]), .TRB_CLR(off[1]), .SUP_SET(lvl[2]), .SUP_CLR(off[2]),
      .LED_POWER(leds[4]), .LED_ALARM(leds[3]), .LED_PREALARM(leds[0]),
      .LED_TROUBLE(leds[1]), .LED_SUPERVISORY(leds[2]), .LED_SILENCE(leds[5]),
      .SILENCEABLE_ON(sil_on), .IRQ(irq));
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic key(input int b);
      apb(1'b1, `OFS_CTRL, 32'h1 << b);
   endtask
   // mode 0 dark, 1 flashing, 2 steady; twelve samples span a blink period and a half
   task automatic led(input int i, input int mode);
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      repeat (8) @(posedge clk);
      repeat (12)
      begin
         @(negedge clk);
         hi += int'(leds[i] === 1'b1);
         lo += int'(leds[i] === 1'b0);
      end
      chk(32'((hi == 12) ? 2 : (lo == 12) ? 0 : (hi + lo == 12) ? 1 : 3), 32'(mode),
         $sformatf("led %0d mode", i));
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      led(4, 2);
      field_model_i.mains(1'b0);
      led(4, 0);
      @(posedge clk);
      ce <= 1'b0;
      field_model_i.mains(1'b1);
      repeat (10) @(posedge clk);
      chk({31'h0, leds[4]}, 32'h0, "power led frozen");
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, leds[4]}, 32'h1, "power led resumed");
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1, "stat mains");
      apb(1'b0, 12'h010, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000, "unmapped access");
      $display("power test done");
      for (int c = 0; c < 3; c++)
      begin
         field_model_i.raise(c, 0);
         field_model_i.raise(c, 1);
      end
      repeat (8) @(posedge clk);
      repeat (12)
      begin
         @(negedge clk);
         chk({31'h0, leds[0] ^ leds[1]}, 32'h0, "blink phase");
      end
      for (int c = 0; c < 3; c++) led(c, 1);
      key(`CTRL_ACK);
      for (int c = 0; c < 3; c++) led(c, 2);
      for (int c = 0; c < 3; c++) field_model_i.drop(c, 0);
      key(`CTRL_ACK);
      for (int c = 0; c < 3; c++) led(c, 2);
      for (int c = 0; c < 3; c++) field_model_i.drop(c, 1);
      key(`CTRL_ACK);
      for (int c = 0; c < 3; c++) led(c, 0);
      $display("class test done");
      field_model_i.raise(1, 3);
      repeat (8) @(posedge clk);
      key(`CTRL_ACK);
      led(1, 2);
      repeat (REV) @(posedge clk);
      led(1, 1);
      $display("revert test done");
      apb(1'b1, `OFS_IRQ_MASK, 32'h0);
      field_model_i.raise(3, 2);
      led(3, 1);
      key(`CTRL_SILENCE);
      led(5, 0);
      key(`CTRL_ACK);
      led(3, 2);
      repeat (25) @(posedge clk);
      key(`CTRL_SILENCE);
      key(`CTRL_SILENCE);
      led(5, 2);
      chk({31'h0, sil_on}, 32'h0, "outputs silenced");
      chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, `OFS_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b1, `OFS_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      repeat (25) @(posedge clk);
      key(`CTRL_SILENCE);
      led(5, 0);
      chk({31'h0, sil_on}, 32'h1, "outputs back on");
      repeat (25) @(posedge clk);
      key(`CTRL_SILENCE);
      key(`CTRL_RESET);
      led(3, 2);
      field_model_i.drop(3, 2);
      led(3, 1);
      key(`CTRL_ACK);
      led(3, 2);
      key(`CTRL_RESET);
      led(3, 0);
      led(5, 0);
      chk({31'h0, sil_on}, 32'h1, "outputs after reset");
      $display("alarm test done");
      close_out();
   end
endmodule
